//--- hw/bwc_pkg.sv
// Constants and types shared by the bus and wake control register bank.
package bwc_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_BUS_XCVR = 7'h04;
    localparam logic [6:0] ADDR_BUS_PEAK = 7'h05;
    localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
    localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;

    // ------------------------------------------------------------------
    // Reset values, writable bits, restart and fail-safe patterns
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BUS_XCVR = 8'h20;
    localparam logic [7:0] RST_BUS_PEAK = 8'h00;
    localparam logic [7:0] RST_INT_WAKE = 8'h00;
    localparam logic [7:0] RST_EXT_WAKE = 8'h07;
    localparam logic [7:0] WMASK_BUS_XCVR = 8'hFB;
    localparam logic [7:0] WMASK_BUS_PEAK = 8'h20;
    localparam logic [7:0] WMASK_INT_WAKE = 8'hC4;
    localparam logic [7:0] WMASK_EXT_WAKE = 8'hA7;
    localparam logic [7:0] KEEP_RS_BUS_XCVR = 8'hE0;
    localparam logic [7:0] KEEP_RS_BUS_PEAK = 8'h20;
    localparam logic [7:0] KEEP_RS_INT_WAKE = 8'hC0;
    localparam logic [7:0] KEEP_RS_EXT_WAKE = 8'hA7;
    localparam logic [7:0] KEEP_FS_BUS_XCVR = 8'hE0;
    localparam logic [7:0] SET_FS_BUS_XCVR = 8'h09;
    localparam logic [7:0] KEEP_FS_EXT_WAKE = 8'hA0;
    localparam logic [7:0] SET_FS_EXT_WAKE = 8'h07;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_LIN_FLASH = 7;
    localparam int POS_LIN_LOW_SLOPE_SELECT = 6;
    localparam int POS_LIN_TXD = 5;
    localparam int POS_LIN_MODE = 3;
    localparam int POS_CAN_MODE = 0;
    localparam int POS_PEAK = 5;
    localparam int POS_TMR2 = 7;
    localparam int POS_TMR1 = 6;
    localparam int POS_WDOG = 2;
    localparam int POS_INT_GLOBAL = 7;
    localparam int POS_MEAS = 5;
    localparam int POS_WAKE_IN = 0;

    // ------------------------------------------------------------------
    // Transceiver mode codes and serial frame counts
    // ------------------------------------------------------------------
    localparam logic [1:0] XCVR_OFF = 2'h0;
    localparam logic [1:0] XCVR_WAKE = 2'h1;
    localparam logic [1:0] XCVR_RX_ONLY = 2'h2;
    localparam logic [1:0] XCVR_NORMAL = 2'h3;
    localparam logic [1:0] XCVR_RESTART = XCVR_WAKE;
    localparam logic [4:0] ADDR_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    typedef enum logic [2:0] {
        BWC_INIT,
        BWC_NORMAL,
        BWC_STOP,
        BWC_RESTART,
        BWC_FAILSAFE
    } bwc_mode_e;

    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic [7:0] data;
    } bwc_frame_s;

    typedef struct packed {
        logic lin_valid;
        logic [1:0] lin_mode;
        logic can_valid;
        logic [1:0] can_mode;
    } bwc_xcvr_upd_s;

    typedef struct packed {
        logic lin_flash_bypass;
        logic lin_low_slope_select;
        logic lin_tx_timeout_en;
        logic [1:0] lin_transceiver_mode;
        logic [1:0] can_transceiver_mode;
        logic supply_peak_threshold_sel;
        logic second_timer_wake_en;
        logic first_timer_wake_en;
        logic wdog_stop_disable_hi;
        logic int_global_all;
        logic wake_measure_select;
        logic measure_enable;
        logic [2:0] wake_in_en;
    } bwc_cfg_s;

endpackage : bwc_pkg

//--- hw/bwc_spi_frame.sv
// Serial frame receiver and read-back shifter for the register bank.
`timescale 1ns/1ps
`default_nettype none
module bwc_spi_frame
    import bwc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic chip_select_n,
    input wire logic spi_clk,
    input wire logic spi_mosi,
    input wire logic [7:0] rd_data,
    output logic [6:0] rd_addr,
    output logic spi_miso,
    output logic frame_done,
    output bwc_frame_s frame
);

    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sck_sync;
        logic [1:0] sdi_sync;
        logic sck_prev;
        logic active;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [7:0] tx;
        logic load;
        logic miso;
        logic done;
        bwc_frame_s frame;
    } bwc_spi_s;

    bwc_spi_s s_q;
    bwc_spi_s s_d;
    logic fall;
    logic rise;

    assign fall = s_q.sck_prev && !s_q.sck_sync[1];
    assign rise = !s_q.sck_prev && s_q.sck_sync[1];

    always_comb begin
        s_d = s_q;
        s_d.cs_sync = {s_q.cs_sync[0], chip_select_n};
        s_d.sck_sync = {s_q.sck_sync[0], spi_clk};
        s_d.sdi_sync = {s_q.sdi_sync[0], spi_mosi};
        s_d.sck_prev = s_q.sck_sync[1];
        s_d.done = 1'b0;
        s_d.load = 1'b0;
        if (s_q.cs_sync[1]) begin
            // Frames shorter than sixteen bits are dropped whole; bits past the sixteenth are ignored.
            if (s_q.active && s_q.cnt == FRAME_BITS) begin
                s_d.done = 1'b1;
                s_d.frame.addr = s_q.rx[6:0];
                s_d.frame.wr = s_q.rx[7];
                s_d.frame.data = s_q.rx[15:8];
            end
            s_d.active = 1'b0;
            s_d.cnt = 5'h00;
            s_d.miso = 1'b0;
        end else begin
            s_d.active = 1'b1;
            if (fall && s_q.cnt < FRAME_BITS) begin
                s_d.rx[s_q.cnt[3:0]] = s_q.sdi_sync[1];
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.load = (s_q.cnt == ADDR_BITS - 5'h01);
            end
            // The old contents are captured before any write can land.
            if (s_q.load) begin
                s_d.tx = rd_data; // R20
            end
            if (rise && s_q.cnt >= ADDR_BITS) begin
                s_d.miso = s_q.tx[0];
                s_d.tx = {1'b0, s_q.tx[7:1]};
            end
        end
        if (!rstn) begin
            s_d = '0;
            s_d.cs_sync = 2'h3;
        end
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign rd_addr = s_q.rx[6:0];
    assign spi_miso = s_q.miso;
    assign frame_done = s_q.done;
    assign frame = s_q.frame;

endmodule : bwc_spi_frame
`default_nettype wire

//--- hw/bwc_bus_wake_regs.sv
// Bus transceiver and wake source register bank behind the serial port.
//
// Operation
// R1: LIN flash bit 7: 0 slope control on, 1 slope control off.
// R2: LIN low-slope bit 6: 0 normal LIN, 1 reduced-slope mode.
// R3: LIN transmit time-out bit 5: 0 supervision off, 1 on.
// R4: LIN mode bits 4:3: off, wake capable, receive only, normal.
// R5: CAN mode bits 1:0: off, wake capable, receive only, normal.
// R6: LIN option changes apply at chip select release, to all LIN parts.
// R7: Fail-safe entry forces transceiver and external wake wake patterns.
// R8: Reserved bits always read as zero.
// R9: Peak threshold bit 5: 0 low threshold, 1 higher threshold.
// R10: Peak bit writable in init and normal; stop ignores writes silently.
// R11: Internal wake bits 7 and 6 enable second and first timer wake.
// R12: Internal wake bit 2 disables watchdog in stop mode when set.
// R13: Interrupt select bit 7: 0 wake sources only, 1 all status.
// R14: Measure select set enables measuring and masks wake inputs a and b; the code enables measuring in normal mode only.
// R15: Wake input enable bits 2..0 enable each wake input.
// R16: Host sets transceiver mode to wake capable for bus wake.
// R17: Power-on or soft reset loads 07, 00, 00 into wake registers.
// R18: Transceiver mode reset values depend on the reset cause.
// R19: Restart keeps peak bit and interrupt, measure, wake enables only; the code also keeps LIN bits 7:5.
// R20: Write frames return the contents held before that write.
// R21: Device state logic may update transceiver modes; reads show it.
`timescale 1ns/1ps
`default_nettype none
module bwc_bus_wake_regs
    import bwc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic chip_select_n,
    input wire logic spi_clk,
    input wire logic spi_mosi,
    input wire bwc_mode_e sbc_mode,
    input wire logic soft_reset_req,
    input wire logic restart_entry,
    input wire logic fail_safe_entry,
    input wire bwc_xcvr_upd_s xcvr_upd,
    output logic spi_miso,
    output bwc_cfg_s cfg
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] bus_xcvr;
        logic [7:0] bus_peak;
        logic [7:0] int_wake;
        logic [7:0] ext_wake;
        bwc_cfg_s cfg;
    } bwc_regs_s;

    bwc_regs_s s_q;
    bwc_regs_s s_d;
    bwc_frame_s frame;
    logic frame_done;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_hit;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] reg_read(input bwc_regs_s s, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_BUS_XCVR) begin
            v = s.bus_xcvr;
        end else if (a == ADDR_BUS_PEAK) begin
            v = s.bus_peak;
        end else if (a == ADDR_INT_WAKE) begin
            v = s.int_wake;
        end else if (a == ADDR_EXT_WAKE) begin
            v = s.ext_wake;
        end
        return v;
    endfunction : reg_read

    function automatic bwc_cfg_s decode(input bwc_regs_s s, input bwc_mode_e m);
        bwc_cfg_s c;
        c.lin_flash_bypass = s.bus_xcvr[POS_LIN_FLASH]; // R1
        c.lin_low_slope_select = s.bus_xcvr[POS_LIN_LOW_SLOPE_SELECT]; // R2
        c.lin_tx_timeout_en = s.bus_xcvr[POS_LIN_TXD]; // R3
        c.lin_transceiver_mode = s.bus_xcvr[POS_LIN_MODE +: 2]; // R4
        c.can_transceiver_mode = s.bus_xcvr[POS_CAN_MODE +: 2]; // R5
        c.supply_peak_threshold_sel = s.bus_peak[POS_PEAK]; // R9
        c.second_timer_wake_en = s.int_wake[POS_TMR2]; // R11
        c.first_timer_wake_en = s.int_wake[POS_TMR1]; // R11
        c.wdog_stop_disable_hi = s.int_wake[POS_WDOG]; // R12
        c.int_global_all = s.ext_wake[POS_INT_GLOBAL]; // R13
        c.wake_measure_select = s.ext_wake[POS_MEAS];
        // Measuring only runs in normal mode; the wake masking holds always.
        c.measure_enable = s.ext_wake[POS_MEAS] && (m == BWC_NORMAL); // R14
        c.wake_in_en = s.ext_wake[POS_WAKE_IN +: 3]
            & {1'b1, {2{!s.ext_wake[POS_MEAS]}}}; // R14 R15
        return c;
    endfunction : decode

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    bwc_spi_frame u_spi (
        .clock(clock),
        .rstn(rstn),
        .chip_select_n(chip_select_n),
        .spi_clk(spi_clk),
        .spi_mosi(spi_mosi),
        .rd_data(rd_data),
        .rd_addr(rd_addr),
        .spi_miso(spi_miso),
        .frame_done(frame_done),
        .frame(frame)
    );

    assign rd_data = reg_read(s_q, rd_addr); // R20
    assign wr_hit = frame_done && frame.wr;

    // ------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (!rstn || soft_reset_req) begin
            // Both resets leave the transceivers off with time-out enabled.
            s_d.bus_xcvr = RST_BUS_XCVR; // R18
            s_d.bus_peak = RST_BUS_PEAK; // R17
            s_d.int_wake = RST_INT_WAKE; // R17
            s_d.ext_wake = RST_EXT_WAKE; // R17
        end else if (fail_safe_entry) begin
            // Wake must stay possible whatever the host had configured.
            s_d.bus_xcvr = (s_q.bus_xcvr & KEEP_FS_BUS_XCVR) | SET_FS_BUS_XCVR; // R7
            s_d.ext_wake = (s_q.ext_wake & KEEP_FS_EXT_WAKE) | SET_FS_EXT_WAKE; // R7
        end else if (restart_entry) begin
            s_d.bus_xcvr = s_q.bus_xcvr & KEEP_RS_BUS_XCVR;
            s_d.bus_xcvr[POS_LIN_MODE +: 2] = XCVR_RESTART; // R18
            s_d.bus_xcvr[POS_CAN_MODE +: 2] = XCVR_RESTART; // R18
            s_d.bus_peak = s_q.bus_peak & KEEP_RS_BUS_PEAK; // R19
            s_d.int_wake = s_q.int_wake & KEEP_RS_INT_WAKE;
            s_d.ext_wake = s_q.ext_wake & KEEP_RS_EXT_WAKE; // R19
        end else begin
            if (wr_hit) begin
                // Reserved bits are never stored, so they read back as zero.
                if (frame.addr == ADDR_BUS_XCVR) begin
                    s_d.bus_xcvr = frame.data & WMASK_BUS_XCVR; // R6 R8
                end else if (frame.addr == ADDR_BUS_PEAK) begin
                    // Stop mode drops the write quietly; no error is flagged.
                    if (sbc_mode != BWC_STOP) begin
                        s_d.bus_peak = frame.data & WMASK_BUS_PEAK; // R10
                    end
                end else if (frame.addr == ADDR_INT_WAKE) begin
                    s_d.int_wake = frame.data & WMASK_INT_WAKE; // R8
                end else if (frame.addr == ADDR_EXT_WAKE) begin
                    s_d.ext_wake = frame.data & WMASK_EXT_WAKE; // R8
                end
            end
            // Hardware mode changes win over a host write in the same cycle.
            if (xcvr_upd.lin_valid) begin
                s_d.bus_xcvr[POS_LIN_MODE +: 2] = xcvr_upd.lin_mode; // R21
            end
            if (xcvr_upd.can_valid) begin
                s_d.bus_xcvr[POS_CAN_MODE +: 2] = xcvr_upd.can_mode; // R21
            end
        end
        s_d.cfg = decode(s_d, sbc_mode);
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign cfg = s_q.cfg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    logic quiet;
    assign quiet = !soft_reset_req && !fail_safe_entry && !restart_entry;

    property p_fs_xcvr;
        fail_safe_entry && !soft_reset_req |=>
            s_q.bus_xcvr[4:0] == SET_FS_BUS_XCVR[4:0]
            && s_q.bus_xcvr[7:5] == $past(s_q.bus_xcvr[7:5])
            && cfg.can_transceiver_mode == XCVR_WAKE;
    endproperty
    a_fs_xcvr: assert property (p_fs_xcvr) // R7
        else $error("fail-safe transceiver pattern wrong");

    property p_fs_wake;
        fail_safe_entry && !soft_reset_req |=>
            (s_q.ext_wake & ~KEEP_FS_EXT_WAKE) == SET_FS_EXT_WAKE
            && cfg.wake_in_en[2];
    endproperty
    a_fs_wake: assert property (p_fs_wake) // R7
        else $error("fail-safe wake pattern wrong");

    property p_reserved;
        (s_q.bus_xcvr & ~WMASK_BUS_XCVR) == 8'h00
        && (s_q.bus_peak & ~WMASK_BUS_PEAK) == 8'h00
        && (s_q.int_wake & ~WMASK_INT_WAKE) == 8'h00
        && (s_q.ext_wake & ~WMASK_EXT_WAKE) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) // R8
        else $error("reserved bit reads as one");

    property p_peak_stop;
        quiet && sbc_mode == BWC_STOP && wr_hit && frame.addr == ADDR_BUS_PEAK
            |=> $stable(s_q.bus_peak) && $stable(cfg.supply_peak_threshold_sel);
    endproperty
    a_peak_stop: assert property (p_peak_stop) // R10
        else $error("peak threshold changed in stop mode");

    property p_peak_write;
        quiet && sbc_mode == BWC_NORMAL && wr_hit && frame.addr == ADDR_BUS_PEAK
            |=> cfg.supply_peak_threshold_sel == $past(frame.data[POS_PEAK]);
    endproperty
    a_peak_write: assert property (p_peak_write) // R9 R10
        else $error("peak threshold write lost in normal mode");

    property p_meas;
        s_q.ext_wake[POS_MEAS] |-> cfg.wake_in_en[1:0] == 2'h0
            && cfg.wake_in_en[2] == s_q.ext_wake[POS_WAKE_IN + 2];
    endproperty
    a_meas: assert property (p_meas) // R14 R15
        else $error("wake inputs not masked by measure select");

    property p_soft;
        soft_reset_req |=> s_q.ext_wake == RST_EXT_WAKE
            && s_q.int_wake == RST_INT_WAKE && s_q.bus_peak == RST_BUS_PEAK
            && s_q.bus_xcvr == RST_BUS_XCVR;
    endproperty
    a_soft: assert property (p_soft) // R17 R18
        else $error("soft reset values wrong");

    property p_restart;
        restart_entry && !soft_reset_req && !fail_safe_entry |=>
            s_q.bus_peak == ($past(s_q.bus_peak) & KEEP_RS_BUS_PEAK)
            && s_q.ext_wake == ($past(s_q.ext_wake) & KEEP_RS_EXT_WAKE);
    endproperty
    a_restart: assert property (p_restart) // R19
        else $error("restart values wrong");

    property p_lin_write;
        quiet && !xcvr_upd.lin_valid && wr_hit && frame.addr == ADDR_BUS_XCVR
            |=> cfg.lin_flash_bypass == $past(frame.data[POS_LIN_FLASH])
            && cfg.lin_low_slope_select == $past(frame.data[POS_LIN_LOW_SLOPE_SELECT])
            && cfg.lin_tx_timeout_en == $past(frame.data[POS_LIN_TXD]);
    endproperty
    a_lin_write: assert property (p_lin_write) // R1 R2 R3 R6
        else $error("LIN options not applied after frame");

    logic rd_data_lin_ok;
    assign rd_data_lin_ok = s_q.bus_xcvr[POS_LIN_MODE +: 2] == cfg.lin_transceiver_mode;

    property p_hw_upd;
        quiet && xcvr_upd.lin_valid && xcvr_upd.can_valid |=>
            cfg.lin_transceiver_mode == $past(xcvr_upd.lin_mode)
            && cfg.can_transceiver_mode == $past(xcvr_upd.can_mode)
            && rd_data_lin_ok;
    endproperty

    a_hw_upd: assert property (p_hw_upd) // R4 R5 R21
        else $error("hardware mode update not visible");

    property p_timers;
        quiet && wr_hit && frame.addr == ADDR_INT_WAKE |=>
            cfg.second_timer_wake_en == $past(frame.data[POS_TMR2])
            && cfg.first_timer_wake_en == $past(frame.data[POS_TMR1])
            && cfg.wdog_stop_disable_hi == $past(frame.data[POS_WDOG]);
    endproperty
    a_timers: assert property (p_timers) // R11 R12
        else $error("internal wake write not applied");

    property p_int_sel;
        quiet && wr_hit && frame.addr == ADDR_EXT_WAKE |=>
            cfg.int_global_all == $past(frame.data[POS_INT_GLOBAL])
            && cfg.wake_measure_select == $past(frame.data[POS_MEAS]);
    endproperty
    a_int_sel: assert property (p_int_sel) // R13
        else $error("interrupt select not applied");

    property p_restart_modes;
        restart_entry && !soft_reset_req && !fail_safe_entry |=>
            cfg.lin_transceiver_mode == XCVR_RESTART
            && cfg.can_transceiver_mode == XCVR_RESTART
            && s_q.bus_xcvr[7:5] == $past(s_q.bus_xcvr[7:5])
            && s_q.int_wake == ($past(s_q.int_wake) & KEEP_RS_INT_WAKE);
    endproperty
    a_restart_modes: assert property (p_restart_modes) // R18
        else $error("restart transceiver modes wrong");

    property p_hold;
        quiet && !frame_done && !xcvr_upd.lin_valid && !xcvr_upd.can_valid
            |=> $stable(s_q.bus_xcvr) && $stable(s_q.bus_peak)
            && $stable(s_q.int_wake) && $stable(s_q.ext_wake);
    endproperty
    a_hold: assert property (p_hold) // R6
        else $error("register changed outside a frame end");

endmodule : bwc_bus_wake_regs
`default_nettype wire

//--- dv/bwc_host_model.sv
// Host side serial master that frames register accesses for the bank.
`timescale 1ns/1ps
`default_nettype none
module bwc_host_model (
    input wire logic clock,
    output logic chip_select_n,
    output logic spi_clk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    // ------------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------------
    // Five clocks per half period keeps clear of the pin synchronisers.
    localparam int HALF = 5;

    initial begin
        chip_select_n = 1'b1;
        spi_clk = 1'b0;
        spi_mosi = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
        rdata = 8'h00;
        chip_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            tick(HALF);
            spi_clk = 1'b1;
            // Data moves on the rising edge, so it is settled well before the sampling fall.
            spi_mosi = word[i];
            tick(HALF);
            if (i >= 8) begin
                rdata[i-8] = spi_miso;
            end
            spi_clk = 1'b0;
        end
        tick(HALF);
        chip_select_n = 1'b1;
        // A released data line flips so a stale bit never looks driven.
        spi_mosi = ~spi_mosi;
        tick(HALF);
    endtask : xfer
endmodule : bwc_host_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the bus and wake control register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bwc_pkg::*;
;
    logic clock, rstn, soft_reset_req, restart_entry, fail_safe_entry;
    logic chip_select_n, spi_clk, spi_mosi, spi_miso;
    bwc_mode_e sbc_mode;
    bwc_xcvr_upd_s xcvr_upd;
    bwc_cfg_s cfg;
    logic [7:0] mreg [4:7];
    logic [7:0] rd;
    logic [15:0] lfsr;
    int error_cnt, n_checks;

    bwc_bus_wake_regs i_dut (.clock(clock), .rstn(rstn), .chip_select_n(chip_select_n),
        .spi_clk(spi_clk), .spi_mosi(spi_mosi), .sbc_mode(sbc_mode),
        .soft_reset_req(soft_reset_req), .restart_entry(restart_entry),
        .fail_safe_entry(fail_safe_entry), .xcvr_upd(xcvr_upd), .spi_miso(spi_miso), .cfg(cfg));
    bwc_host_model i_host (.clock(clock), .chip_select_n(chip_select_n), .spi_clk(spi_clk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next

    function automatic logic [7:0] wmask(input logic [6:0] a);
        case (a)
            ADDR_BUS_XCVR: return WMASK_BUS_XCVR;
            ADDR_BUS_PEAK: return WMASK_BUS_PEAK;
            ADDR_INT_WAKE: return WMASK_INT_WAKE;
            ADDR_EXT_WAKE: return WMASK_EXT_WAKE;
            default: return 8'h00;
        endcase
    endfunction : wmask

    function automatic bwc_cfg_s exp_cfg();
        bwc_cfg_s c;
        c.lin_flash_bypass = mreg[4][7];
        c.lin_low_slope_select = mreg[4][6];
        c.lin_tx_timeout_en = mreg[4][5];
        c.lin_transceiver_mode = mreg[4][4:3];
        c.can_transceiver_mode = mreg[4][1:0];
        c.supply_peak_threshold_sel = mreg[5][5];
        c.second_timer_wake_en = mreg[6][7];
        c.first_timer_wake_en = mreg[6][6];
        c.wdog_stop_disable_hi = mreg[6][2];
        c.int_global_all = mreg[7][7];
        c.wake_measure_select = mreg[7][5];
        c.measure_enable = mreg[7][5] && (sbc_mode == BWC_NORMAL);
        c.wake_in_en = mreg[7][5] ? {mreg[7][2], 2'b00} : mreg[7][2:0];
        return c;
    endfunction : exp_cfg

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_byte

    task automatic chk_cfg(input bwc_cfg_s exp, input bwc_cfg_s got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value cfg expected %h seen %h", exp, got);
        end
    endtask : chk_cfg

    // One frame, then the read-back and the decoded outputs are compared.
    task automatic access(input logic [6:0] addr, input logic wr, input logic [7:0] data);
        logic mapped;
        logic [7:0] exp;
        mapped = (addr >= ADDR_BUS_XCVR) && (addr <= ADDR_EXT_WAKE);
        exp = mapped ? mreg[addr] : 8'h00;
        i_host.xfer({data, wr, addr}, 16, rd);
        chk_byte("read data", exp, rd);
        if (wr && mapped && !(addr == ADDR_BUS_PEAK && sbc_mode == BWC_STOP)) begin
            mreg[addr] = data & wmask(addr);
        end
        tick(3);
        chk_cfg(exp_cfg(), cfg);
    endtask : access

    task automatic pulse(input int kind);
        case (kind)
            0: soft_reset_req = 1'b1;
            1: restart_entry = 1'b1;
            2: fail_safe_entry = 1'b1;
            default: xcvr_upd = '{1'b1, XCVR_RX_ONLY, 1'b1, XCVR_NORMAL};
        endcase
        tick(1);
        {soft_reset_req, restart_entry, fail_safe_entry} = 3'b000;
        xcvr_upd = '0;
        tick(1);
    endtask : pulse

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        {soft_reset_req, restart_entry, fail_safe_entry} = 3'b000;
        xcvr_upd = '0;
        sbc_mode = BWC_INIT;
        error_cnt = 0;
        n_checks = 0;
        lfsr = 16'h7078;
        mreg = '{RST_BUS_XCVR, RST_BUS_PEAK, RST_INT_WAKE, RST_EXT_WAKE};
        tick(2);
        rstn = 1'b1;
        tick(4);
        for (int a = 4; a < 9; a++) access(7'(a), 1'b0, 8'h00);
        $display("test reset values done");
        // Mode code 01 is the wake-capable setting a host uses for bus wake.
        for (int m = 0; m < 4; m++) access(ADDR_BUS_XCVR, 1'b1, {3'h5, 2'(m), 1'b1, 2'(m)});
        sbc_mode = BWC_STOP;
        access(ADDR_BUS_PEAK, 1'b1, 8'hFF);
        sbc_mode = BWC_NORMAL;
        access(ADDR_BUS_PEAK, 1'b1, 8'hFF);
        $display("test mode codes done");
        for (int k = 0; k < 24; k++) begin
            lfsr = lfsr_next(lfsr);
            sbc_mode = bwc_mode_e'(3'(lfsr[15:14] % 2'h3));
            access((lfsr[12] & lfsr[13]) ? 7'h0A : 7'(4 + lfsr[11:10]),
                lfsr[8] | lfsr[9], lfsr[7:0]);
        end
        $display("test random access done");
        i_host.xfer({8'h00, 1'b1, ADDR_EXT_WAKE}, 12, rd);
        access(ADDR_EXT_WAKE, 1'b0, 8'h00);
        $display("test short frame done");
        for (int k = 3; k >= 0; k--) begin
            access(ADDR_EXT_WAKE, 1'b1, 8'hFF);
            access(ADDR_INT_WAKE, 1'b1, 8'hFF);
            access(ADDR_BUS_XCVR, 1'b1, 8'hFF);
            pulse(k);
            case (k)
                0: mreg = '{RST_BUS_XCVR, RST_BUS_PEAK, RST_INT_WAKE, RST_EXT_WAKE};
                1: mreg = '{(mreg[4] & 8'hE0) | 8'h09, mreg[5] & 8'h20, mreg[6] & 8'hC0,
                        mreg[7] & 8'hA7};
                2: mreg = '{(mreg[4] & 8'hE0) | 8'h09, mreg[5], mreg[6],
                        (mreg[7] & 8'hA0) | 8'h07};
                default: mreg[4] = {mreg[4][7:5], XCVR_RX_ONLY, 1'b0, XCVR_NORMAL};
            endcase
            chk_cfg(exp_cfg(), cfg);
            for (int a = 4; a < 8; a++) access(7'(a), 1'b0, 8'h00);
        end
        $display("test device events done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
